// ==== hdl/bpd_params.svh ====
// Register map, field positions and reset values of the port block
`ifndef BPD_PARAMS_SVH
`define BPD_PARAMS_SVH

// ===========================================================
// Register byte offsets
`define BPD_OFS_PIN_LEVELS 12'h000
`define BPD_OFS_OUTPUT_LATCH 12'h004
`define BPD_OFS_DIRECTION 12'h008
`define BPD_OFS_PORT_E_DIRECTION 12'h00c
`define BPD_OFS_STATUS 12'h010

// ===========================================================
// Field positions
`define BPD_SLAVE_PORT_SELECT_BIT 4
`define BPD_PORT_E_DIR_LO_BIT 0
`define BPD_PORT_E_DIR_HI_BIT 2
`define BPD_PWM_B_PIN 5
`define BPD_PWM_C_PIN 6
`define BPD_PWM_D_PIN 7
`define BPD_STAT_SLAVE_ACTIVE_BIT 0
`define BPD_STAT_SLAVE_BLOCKED_BIT 1
`define BPD_STAT_OE_LSB 8
`define BPD_STAT_OUT_LSB 16

// ===========================================================
// Reset values
`define BPD_RST_OUTPUT_LATCH 8'h00
`define BPD_RST_DIRECTION 8'hff
`define BPD_RST_PORT_E_DIRECTION 8'h07

`endif

// ==== hdl/bpd_pkg.sv ====
// Types shared by the port block
package bpd_pkg;

   // ===========================================================
   // Enhanced PWM output configuration
   typedef enum logic [1:0] {
      BPD_PWM_SINGLE = 2'b00,
      BPD_PWM_QUAD_FWD = 2'b01,
      BPD_PWM_DUAL = 2'b10,
      BPD_PWM_QUAD_REV = 2'b11
   } bpd_pwm_mode_t;

   // ===========================================================
   // Signals from the enhanced capture/PWM unit, same clock
   typedef struct packed {
      logic enable;
      bpd_pwm_mode_t mode;
      logic channel_b;
      logic channel_c;
      logic channel_d;
      logic shutdown;
      logic shutdown_tristate;
   } bpd_pwm_in_t;

   // ===========================================================
   // Slave port side: read drive request from its handshake logic
   typedef struct packed {
      logic read_drive;
   } bpd_slave_in_t;

   // ===========================================================
   // Drive of the eight pins
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } bpd_pin_drive_t;

   // ===========================================================
   // Bus slave answer sequencing
   typedef enum logic [0:0] {
      BPD_BUS_IDLE = 1'b0,
      BPD_BUS_ANSWER = 1'b1
   } bpd_bus_state_t;

endpackage

// ==== hdl/bpd_sync.sv ====
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none

module bpd_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // First stage is read only by the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule

`default_nettype wire

// ==== hdl/bpd_port.sv ====
// Eight-pin bidirectional port with slave-port and PWM pin override
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "bpd_params.svh"

module bpd_port #(
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port pins
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe,
   // Enhanced PWM unit
   input wire bpd_pkg::bpd_pwm_in_t pwm_in,
   // Parallel slave interface
   input wire bpd_pkg::bpd_slave_in_t slave_in,
   output logic [PINS-1:0] slave_write_data,
   output logic slave_port_active
);

   // ===========================================================
   // Declarations
   logic [PINS-1:0] pin_sync;
   logic [PINS-1:0] port_d_output_latch;
   logic [PINS-1:0] port_d_direction;
   logic [7:0] port_e_direction;
   bpd_pkg::bpd_bus_state_t bus_state;
   bpd_pkg::bpd_bus_state_t next_bus_state;
   logic bus_setup;
   logic bus_commit;
   logic addr_hit;
   logic [31:0] next_prdata;
   logic slave_select;
   logic pwm_multi;
   logic pwm_quad;
   logic slave_blocked;
   logic slave_active;
   logic [PINS-1:0] pwm_own;
   logic [PINS-1:0] pwm_level;
   bpd_pkg::bpd_pin_drive_t next_drive;

   // ===========================================================
   // Pin input synchroniser
   // A pin level must stand three edges before a read can see it
   bpd_sync #(
      .WIDTH(PINS)
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // ===========================================================
   // Bus sequencing: one wait state, answer in the second access cycle
   // Read data are latched in the first access cycle, so a read of the
   // pin levels sees them as they stood a few edges before pready
   assign bus_setup = psel && penable && !pready;
   assign bus_commit = psel && penable && pready;

   always_comb begin
      next_bus_state = bus_state;
      unique case (bus_state)
         bpd_pkg::BPD_BUS_IDLE: begin
            if (bus_setup) begin
               next_bus_state = bpd_pkg::BPD_BUS_ANSWER;
            end
         end
         bpd_pkg::BPD_BUS_ANSWER: begin
            next_bus_state = bpd_pkg::BPD_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= bpd_pkg::BPD_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= (next_bus_state == bpd_pkg::BPD_BUS_ANSWER);
      end
   end

   // ===========================================================
   // Address decode
   // Unmapped addresses still answer on time, with an error flag, so a
   // stray access never hangs the bus; the write itself is dropped
   always_comb begin
      unique case (paddr)
         `BPD_OFS_PIN_LEVELS: addr_hit = 1'b1;
         `BPD_OFS_OUTPUT_LATCH: addr_hit = 1'b1;
         `BPD_OFS_DIRECTION: addr_hit = 1'b1;
         `BPD_OFS_PORT_E_DIRECTION: addr_hit = 1'b1;
         `BPD_OFS_STATUS: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= bus_setup && !addr_hit;
      end
   end

   // ===========================================================
   // Read data, captured one cycle ahead of pready
   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         `BPD_OFS_PIN_LEVELS: begin
            next_prdata[PINS-1:0] = pin_sync;
         end
         `BPD_OFS_OUTPUT_LATCH: begin
            next_prdata[PINS-1:0] = port_d_output_latch;
         end
         `BPD_OFS_DIRECTION: begin
            next_prdata[PINS-1:0] = port_d_direction;
         end
         `BPD_OFS_PORT_E_DIRECTION: begin
            next_prdata[7:0] = port_e_direction;
         end
         `BPD_OFS_STATUS: begin
            next_prdata[`BPD_STAT_SLAVE_ACTIVE_BIT] = slave_port_active;
            next_prdata[`BPD_STAT_SLAVE_BLOCKED_BIT] = slave_blocked;
            next_prdata[`BPD_STAT_OE_LSB +: PINS] = pin_oe;
            next_prdata[`BPD_STAT_OUT_LSB +: PINS] = pin_out;
         end
         default: begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (bus_setup && !pwrite) begin
         prdata <= next_prdata;
      end else if (bus_commit) begin
         prdata <= 32'h0000_0000;
      end
   end

   // ===========================================================
   // Output latch: both the port and the latch address write it,
   // so a read-modify-write through the latch address never copies pin levels into the latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_d_output_latch <= `BPD_RST_OUTPUT_LATCH;
      end else if (bus_commit && pwrite) begin
         if (paddr == `BPD_OFS_PIN_LEVELS) begin
            port_d_output_latch <= pwdata[PINS-1:0];
         end else if (paddr == `BPD_OFS_OUTPUT_LATCH) begin
            port_d_output_latch <= pwdata[PINS-1:0];
         end
      end
   end

   // ===========================================================
   // Direction registers
   // All ones after reset: no pin is driven by the port until software clears
   // its direction bit; PWM-owned pins and an active slave port ignore the bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_d_direction <= `BPD_RST_DIRECTION;
      end else if (bus_commit && pwrite &&
                   paddr == `BPD_OFS_DIRECTION) begin
         port_d_direction <= pwdata[PINS-1:0];
      end
   end

   // Only the slave select and the three low direction bits exist;
   // the rest read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_e_direction <= `BPD_RST_PORT_E_DIRECTION;
      end else if (bus_commit && pwrite &&
                   paddr == `BPD_OFS_PORT_E_DIRECTION) begin
         port_e_direction <= 8'h00;
         port_e_direction[`BPD_SLAVE_PORT_SELECT_BIT] <=
            pwdata[`BPD_SLAVE_PORT_SELECT_BIT];
         port_e_direction[`BPD_PORT_E_DIR_HI_BIT:`BPD_PORT_E_DIR_LO_BIT]
            <= pwdata[`BPD_PORT_E_DIR_HI_BIT:`BPD_PORT_E_DIR_LO_BIT];
      end
   end

   // ===========================================================
   // Mode resolution
   assign slave_select = port_e_direction[`BPD_SLAVE_PORT_SELECT_BIT];
   assign pwm_multi = pwm_in.enable &&
                      (pwm_in.mode != bpd_pkg::BPD_PWM_SINGLE);
   // Both quad directions use all three shared channels
   assign pwm_quad = pwm_in.enable &&
                     (pwm_in.mode == bpd_pkg::BPD_PWM_QUAD_FWD ||
                      pwm_in.mode == bpd_pkg::BPD_PWM_QUAD_REV);
   assign slave_blocked = slave_select && pwm_multi;
   assign slave_active = slave_select && !pwm_multi;

   // Channel B is used by dual and quad, C and D by quad only
   // Shutdown without tristate keeps the channel level on the pin
   always_comb begin
      pwm_own = '0;
      pwm_level = '0;
      if (pwm_multi) begin
         pwm_own[`BPD_PWM_B_PIN] = 1'b1;
         pwm_level[`BPD_PWM_B_PIN] = pwm_in.channel_b;
      end
      if (pwm_quad) begin
         pwm_own[`BPD_PWM_C_PIN] = 1'b1;
         pwm_own[`BPD_PWM_D_PIN] = 1'b1;
         pwm_level[`BPD_PWM_C_PIN] = pwm_in.channel_c;
         pwm_level[`BPD_PWM_D_PIN] = pwm_in.channel_d;
      end
   end

   // ===========================================================
   // Pin drive, per pin priority: PWM, then slave port, then port
   // Registered drive keeps the pins free of glitches while the priority
   // logic settles; the cost is one cycle of latency on every change
   always_comb begin
      next_drive.out = '0;
      next_drive.oe = '0;
      for (int i = 0; i < PINS; i++) begin
         if (pwm_own[i]) begin
            next_drive.out[i] = pwm_level[i];
            next_drive.oe[i] =
               !(pwm_in.shutdown && pwm_in.shutdown_tristate);
         end else if (slave_active) begin
            // Direction bits are ignored here
            next_drive.out[i] = port_d_output_latch[i];
            next_drive.oe[i] = slave_in.read_drive;
         end else if (port_d_direction[i]) begin
            next_drive.out[i] = port_d_output_latch[i];
            next_drive.oe[i] = 1'b0;
         end else begin
            next_drive.out[i] = port_d_output_latch[i];
            next_drive.oe[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= next_drive.out;
         pin_oe <= next_drive.oe;
      end
   end

   // ===========================================================
   // Slave port write path: pins as inputs whatever the direction
   // Taken every cycle: the strobe that qualifies the byte lives in the
   // handshake logic outside, which picks the cycle it needs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slave_write_data <= '0;
         slave_port_active <= 1'b0;
      end else begin
         slave_write_data <= pin_sync;
         slave_port_active <= slave_active;
      end
   end

endmodule

`default_nettype wire

// ==== test/bpd_port_sva.sv ====
// Assertion checker for the port block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module bpd_port_sva #(
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus answer
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and neighbours
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe,
   input wire bpd_pkg::bpd_pwm_in_t pwm_in,
   input wire bpd_pkg::bpd_slave_in_t slave_in,
   input wire logic [PINS-1:0] slave_write_data,
   input wire logic slave_port_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ===========================================================
   // Bus
   property p_acc_len;
      psel && $rose(penable) |=> pready;
   endproperty
   a_acc_len: assert property (p_acc_len)
      else $error("access too long");
   property p_rdy_once;
      pready |=> !pready;
   endproperty
   a_rdy_once: assert property (p_rdy_once)
      else $error("pready held");
   property p_err_rdy;
      pslverr |-> pready;
   endproperty
   a_err_rdy: assert property (p_err_rdy)
      else $error("lone pslverr");

   // ===========================================================
   // Pins
   property p_rst_in;
      $rose(presetn) |-> pin_oe == '0;
   endproperty
   a_rst_in: assert property (p_rst_in)
      else $error("pin driven at reset");
   property p_blk;
      pwm_in.enable && pwm_in.mode != bpd_pkg::BPD_PWM_SINGLE
         |=> !slave_port_active;
   endproperty
   a_blk: assert property (p_blk)
      else $error("slave port not blocked");
   property p_tri;
      pwm_in.enable && pwm_in.mode != bpd_pkg::BPD_PWM_SINGLE
         && pwm_in.shutdown && pwm_in.shutdown_tristate |=> !pin_oe[5];
   endproperty
   a_tri: assert property (p_tri)
      else $error("shutdown pin driven");
   property p_quad;
      pwm_in.enable && pwm_in.mode[0] && !pwm_in.shutdown |=>
         pin_oe[7:6] == 2'h3 && pin_out[7:6] ==
         {$past(pwm_in.channel_d), $past(pwm_in.channel_c)};
   endproperty
   a_quad: assert property (p_quad)
      else $error("quad channel wrong");
   property p_slv;
      slave_port_active |-> pin_oe[4:0] == {5{$past(slave_in.read_drive)}};
   endproperty
   a_slv: assert property (p_slv)
      else $error("slave drive wrong");
   // Only held levels are compared: the path has a synchroniser in it
   property p_swd;
      $stable(pin_in) [*5] |-> slave_write_data == pin_in;
   endproperty
   a_swd: assert property (p_swd)
      else $error("slave data wrong");

   c_err: cover property (pready && pslverr);
   c_slv: cover property (slave_port_active && slave_in.read_drive);
   c_shd: cover property (pwm_in.enable && pwm_in.shutdown);
endmodule
bind bpd_port bpd_port_sva #(.PINS(PINS)) u_sva (.pclk, .presetn, .psel,
   .penable, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pwm_in,
   .slave_in, .slave_write_data, .slave_port_active);
`default_nettype wire

// ==== test/bpd_pin_world.sv ====
// External circuitry on the eight port pins
`timescale 1ns/100ps
`default_nettype none
module bpd_pin_world (
   // Clock
   input wire logic pclk,
   // Block side
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // Bench side
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_oe,
   output logic [7:0] pin_in
);
   // Undriven pins toggle, so a stale level never passes for a read
   logic [7:0] float_lvl = 8'h00;
   always @(posedge pclk) begin
      float_lvl <= ~float_lvl;
   end
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
      | (~pin_oe & ~ext_oe & float_lvl);
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the port block
`timescale 1ns/100ps
`default_nettype none
`include "bpd_params.svh"
module tb_top;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd_val;
   logic pready, pslverr, rd_err, slave_port_active;
   logic [7:0] pin_in, pin_out, pin_oe, slave_write_data;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ext_oe = 8'h00;
   bpd_pkg::bpd_pwm_in_t pwm_in = '0;
   bpd_pkg::bpd_slave_in_t slave_in = '0;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;

   always #50 pclk = ~pclk;

   bpd_port #(.PINS(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
      .pin_oe, .pwm_in, .slave_in, .slave_write_data, .slave_port_active);
   bpd_pin_world world (.pclk, .pin_out, .pin_oe, .ext_val, .ext_oe,
      .pin_in);

   // ===========================================================
   // Common tasks
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   // Hangs on a dead slave are cut by the cycle ceiling
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd_val = prdata;
      rd_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd_val, exp);
   endtask

   // ===========================================================
   // Scenarios
   task automatic t_reset;
      chk(pin_oe, 8'h00);
      rd(`BPD_OFS_OUTPUT_LATCH, 32'h00);
      rd(`BPD_OFS_DIRECTION, 32'hff);
      apb(1'h0, 12'h020, 32'h0);
      chk(rd_err, 1'h1);
      chk(rd_val, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_port;
      ext_oe <= 8'h0f;
      ext_val <= 8'h3c;
      apb(1'h1, `BPD_OFS_PIN_LEVELS, 32'h5a);
      apb(1'h1, `BPD_OFS_DIRECTION, 32'h0f);
      repeat (4) @(posedge pclk);
      chk(pin_oe, 8'hf0);
      chk(pin_out[7:4], 4'h5);
      rd(`BPD_OFS_PIN_LEVELS, 32'h5c);
      rd(`BPD_OFS_OUTPUT_LATCH, 32'h5a);
      $display("port test done");
   endtask

   task automatic t_slave;
      slave_in.read_drive <= 1'h1;
      apb(1'h1, `BPD_OFS_PORT_E_DIRECTION, 32'hff);
      rd(`BPD_OFS_PORT_E_DIRECTION, 32'h17);
      chk(slave_port_active, 1'h1);
      chk(pin_oe, 8'hff);
      chk(pin_out, 8'h5a);
      ext_oe <= 8'hff;
      ext_val <= 8'ha5;
      slave_in.read_drive <= 1'h0;
      repeat (6) @(posedge pclk);
      chk(pin_oe, 8'h00);
      chk(slave_write_data, 8'ha5);
      $display("slave test done");
   endtask

   task automatic t_pwm;
      logic [7:0] oe, out;
      ext_oe <= 8'h00;
      slave_in.read_drive <= 1'h1;
      for (int m = 0; m < 4; m++) begin
         pwm_in <= {1'h1, 2'(m), 3'h5, 2'h0};
         repeat (3) @(posedge pclk);
         oe = (m == 0) ? 8'hff : 8'hf0;
         out = (m == 0) ? 8'h5a : 8'h7a;
         if (m % 2 == 1) begin
            out[7:6] = 2'h2;
         end
         chk(slave_port_active, m == 0);
         chk(pin_oe, oe);
         chk(pin_out, out);
      end
      pwm_in <= {1'h1, 2'h3, 3'h5, 2'h2};
      repeat (3) @(posedge pclk);
      chk(pin_oe[7:5], 3'h7);
      pwm_in <= {1'h1, 2'h3, 3'h5, 2'h3};
      repeat (3) @(posedge pclk);
      chk(pin_oe[7:5], 3'h0);
      rd(`BPD_OFS_STATUS, 32'h00ba_1002);
      pwm_in <= '0;
      $display("pwm test done");
   endtask

   task automatic t_rerst;
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(pin_oe, 8'h00);
      presetn <= 1'h1;
      rd(`BPD_OFS_DIRECTION, 32'hff);
      $display("second reset test done");
   endtask

   // ===========================================================
   // Sequence and ceiling
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_port;
      t_slave;
      t_pwm;
      t_rerst;
      end_of_test;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         end_of_test;
      end
   end
endmodule
`default_nettype wire
